// [hw/lbim_monitor.sv]
// Leaky bucket accumulators with inactivity alarms and an APB register file.
`default_nettype none
// Functional notes
// - Subtract one per clean run of 1/2/4/8.
// - Decay code 00..11 gives 128..1024 ms.
// - Decay equals fill rate, half, quarter, eighth.
// - Raise alarm when count reaches upper threshold.
// - Set two upper threshold resets to six.
// - Set one decay select resets to 01.
// - Clamp count at programmed bucket size.
// - Clear alarm when count falls to lower.
module lbim_monitor #(
    parameter int NUM_INPUTS = 4,
    parameter int CYCLE_CLKS = lbim_pkg::CYCLE_CLKS
) (
    // Clock, reset and enable.
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // Per-input fault indications from the activity detectors (pins).
    input wire logic [NUM_INPUTS-1:0] fault_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [9:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Alarm and interrupt outputs.
    output logic [NUM_INPUTS-1:0] alarm_o,
    output logic irq_o
);
    logic [NUM_INPUTS-1:0] fault_s1_r;
    logic [NUM_INPUTS-1:0] fault_s2_r;
    logic [NUM_INPUTS-1:0] seen_r;
    logic [31:0] tick_cnt_r;
    logic tick_r;
    lbim_pkg::lbim_cfg_t cfg1_r;
    lbim_pkg::lbim_cfg_t cfg2_r;
    logic [NUM_INPUTS-1:0] cfg_sel_r;
    logic [7:0] fill_r [NUM_INPUTS];
    logic [2:0] clean_r [NUM_INPUTS];
    logic [NUM_INPUTS-1:0] alarm_r;
    logic [NUM_INPUTS-1:0] stat_r;
    logic [NUM_INPUTS-1:0] mask_r;
    logic [NUM_INPUTS-1:0] raise_evt;
    // Read path.
    logic [7:0] rd_idx;
    logic [7:0] fill_sel;
    logic [31:0] prdata_nxt;
    // Write strobes.
    logic wr_upper_1;
    logic wr_lower_1;
    logic wr_size_1;
    logic wr_decay_1;
    logic wr_upper_2;
    logic wr_lower_2;
    logic wr_size_2;
    logic wr_decay_2;
    logic wr_cfg_sel;
    logic wr_mask;
    logic wr_stat;

    // Overview.
    // A free-running divider makes one tick per monitoring cycle. Faults seen on the
    // synchronised pins between two ticks are folded into one sticky bit per input,
    // so a fault of a single clock still costs the input one step of its bucket.
    // On the tick a bucket not clamped to a lowered size moves by at most one: up for a faulty cycle, down
    // after a full clean run. The alarm has hysteresis between the upper and the
    // lower threshold, so a count hovering near one threshold does not chatter.
    // Software sees two configuration sets; each input picks one through the
    // select register. A raised alarm is the only interrupt event.
    // Limitation: settings written in mid-cycle take effect at the next tick, and
    // a size lowered below a count clamps that count at the next tick as well.
    // Keep the clock enable high during APB transfers: a frozen block answers none,
    // and a setup cycle missed that way would leave the master waiting.
    logic wr_en;
    logic rd_en;

    // Access phase completes in one cycle; pready is registered high in it.
    assign wr_en = psel_i && penable_i && pwrite_i && pready_o;
    assign rd_en = psel_i && !penable_i && !pwrite_i;

    // One write strobe per writable register, all qualified by the access phase.
    assign wr_upper_1 = wr_en && (paddr_i == lbim_pkg::OFF_UPPER_THR_1);
    assign wr_lower_1 = wr_en && (paddr_i == lbim_pkg::OFF_LOWER_THR_1);
    assign wr_size_1 = wr_en && (paddr_i == lbim_pkg::OFF_SIZE_1);
    assign wr_decay_1 = wr_en && (paddr_i == lbim_pkg::OFF_DECAY_SEL_1);
    assign wr_upper_2 = wr_en && (paddr_i == lbim_pkg::OFF_UPPER_THR_2);
    assign wr_lower_2 = wr_en && (paddr_i == lbim_pkg::OFF_LOWER_THR_2);
    assign wr_size_2 = wr_en && (paddr_i == lbim_pkg::OFF_SIZE_2);
    assign wr_decay_2 = wr_en && (paddr_i == lbim_pkg::OFF_DECAY_SEL_2);
    assign wr_cfg_sel = wr_en && (paddr_i == lbim_pkg::OFF_CFG_SEL);
    assign wr_mask = wr_en && (paddr_i == lbim_pkg::OFF_IRQ_MASK);
    assign wr_stat = wr_en && (paddr_i == lbim_pkg::OFF_IRQ_STAT);

    // Two-flop synchroniser on the fault pins.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fault_s1_r <= '0;
            fault_s2_r <= '0;
        end else if (clk_en_i) begin
            fault_s1_r <= fault_i;
            fault_s2_r <= fault_s1_r;
        end
    end

    // Monitoring cycle tick; the count is a parameter so benches can shorten it.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (clk_en_i) begin
            tick_r <= 1'b0;
            if (tick_cnt_r == 32'(CYCLE_CLKS - 1)) begin
                tick_cnt_r <= '0;
                tick_r <= 1'b1;
            end else begin
                tick_cnt_r <= tick_cnt_r + 32'h1;
            end
        end
    end

    // Faults are caught sticky across the cycle so a short glitch still counts.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            seen_r <= '0;
        end else if (clk_en_i) begin
            if (tick_r) begin
                seen_r <= fault_s2_r;
            end else begin
                seen_r <= seen_r | fault_s2_r;
            end
        end
    end

    // One bucket per input; each slice only touches its own counters.
    for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_bucket
        lbim_pkg::lbim_cfg_t cfg_use;
        logic [2:0] run_lim;
        logic [7:0] fill_nxt;
        logic [2:0] clean_nxt;
        logic alarm_nxt;

        // Pick the settings that this input is assigned to.
        assign cfg_use = cfg_sel_r[g] ? cfg2_r : cfg1_r;
        // Clean cycles needed per decrement, minus one: 0, 1, 3 or 7.
        assign run_lim = 3'((4'h1 << cfg_use.decay) - 4'h1);

        // Next fill and clean run for the coming tick.
        always_comb begin
            fill_nxt = fill_r[g];
            clean_nxt = clean_r[g];
            if (seen_r[g]) begin
                // A faulty cycle restarts the clean run.
                clean_nxt = 3'h0;
                if (fill_r[g] < cfg_use.size) begin
                    fill_nxt = fill_r[g] + 8'h1;
                end
            end else if (clean_r[g] >= run_lim) begin
                clean_nxt = 3'h0;
                if (fill_r[g] != 8'h0) begin
                    fill_nxt = fill_r[g] - 8'h1;
                end
            end else begin
                clean_nxt = clean_r[g] + 3'h1;
            end
            // A size lowered below the count pulls the count down with it.
            if (fill_nxt > cfg_use.size) begin
                fill_nxt = cfg_use.size;
            end
        end

        // Alarm hysteresis: raise at the upper threshold, drop at the lower one.
        always_comb begin
            alarm_nxt = alarm_r[g];
            if (fill_nxt >= cfg_use.upper) begin
                alarm_nxt = 1'b1;
            end else if (fill_nxt <= cfg_use.lower) begin
                alarm_nxt = 1'b0;
            end
        end

        // Bucket state only moves on the monitoring tick.
        always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                fill_r[g] <= 8'h0;
                clean_r[g] <= 3'h0;
                alarm_r[g] <= 1'b0;
            end else if (clk_en_i && tick_r) begin
                fill_r[g] <= fill_nxt;
                clean_r[g] <= clean_nxt;
                alarm_r[g] <= alarm_nxt;
            end
        end
    end

    // Rising alarms are the interrupt events; alarm_o still holds the previous alarm.
    assign raise_evt = alarm_r & ~alarm_o;

    // Settings of the first configuration; software may change them at any time.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg1_r.upper <= lbim_pkg::RST_UPPER_THR;
            cfg1_r.lower <= lbim_pkg::RST_LOWER_THR;
            cfg1_r.size <= lbim_pkg::RST_SIZE;
            cfg1_r.decay <= lbim_pkg::RST_DECAY_SEL;
        end else if (clk_en_i) begin
            if (wr_upper_1) begin
                cfg1_r.upper <= pwdata_i[7:0];
            end
            if (wr_lower_1) begin
                cfg1_r.lower <= pwdata_i[7:0];
            end
            if (wr_size_1) begin
                cfg1_r.size <= pwdata_i[7:0];
            end
            if (wr_decay_1) begin
                cfg1_r.decay <= pwdata_i[1:0];
            end
        end
    end

    // Settings of the second configuration.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg2_r.upper <= lbim_pkg::RST_UPPER_THR;
            cfg2_r.lower <= lbim_pkg::RST_LOWER_THR;
            cfg2_r.size <= lbim_pkg::RST_SIZE;
            cfg2_r.decay <= lbim_pkg::RST_DECAY_SEL;
        end else if (clk_en_i) begin
            if (wr_upper_2) begin
                cfg2_r.upper <= pwdata_i[7:0];
            end
            if (wr_lower_2) begin
                cfg2_r.lower <= pwdata_i[7:0];
            end
            if (wr_size_2) begin
                cfg2_r.size <= pwdata_i[7:0];
            end
            if (wr_decay_2) begin
                cfg2_r.decay <= pwdata_i[1:0];
            end
        end
    end

    // Per-input choice of configuration: bit i high selects the second set.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_sel_r <= '0;
        end else if (clk_en_i) begin
            if (wr_cfg_sel) begin
                cfg_sel_r <= pwdata_i[NUM_INPUTS-1:0];
            end
        end
    end

    // Interrupt mask; a masked status bit still records its event.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mask_r <= '0;
        end else if (clk_en_i) begin
            if (wr_mask) begin
                mask_r <= pwdata_i[NUM_INPUTS-1:0];
            end
        end
    end

    // Sticky status; a new event wins over a write-one clear in the same cycle.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stat_r <= '0;
        end else if (clk_en_i) begin
            if (wr_stat) begin
                stat_r <= (stat_r & ~pwdata_i[NUM_INPUTS-1:0]) | raise_evt;
            end else begin
                stat_r <= stat_r | raise_evt;
            end
        end
    end

    // Registered outputs.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            alarm_o <= '0;
            irq_o <= 1'b0;
        end else if (clk_en_i) begin
            alarm_o <= alarm_r;
            irq_o <= |(stat_r & mask_r);
        end
    end

    // Word index of the address; the two byte-select bits play no part in it.
    assign rd_idx = paddr_i[9:2];

    // Fill count of the input that the index points at, zero when none matches.
    always_comb begin
        fill_sel = 8'h0;
        for (int i = 0; i < NUM_INPUTS; i++) begin
            if (rd_idx == 8'(lbim_pkg::IDX_FILL_0 + i)) begin
                fill_sel = fill_r[i];
            end
        end
    end

    // Read mux; unused bits and unmapped addresses read as zero.
    always_comb begin
        prdata_nxt = 32'h0;
        unique case (paddr_i)
            lbim_pkg::OFF_UPPER_THR_1: prdata_nxt[7:0] = cfg1_r.upper;
            lbim_pkg::OFF_LOWER_THR_1: prdata_nxt[7:0] = cfg1_r.lower;
            lbim_pkg::OFF_SIZE_1: prdata_nxt[7:0] = cfg1_r.size;
            lbim_pkg::OFF_DECAY_SEL_1: prdata_nxt[1:0] = cfg1_r.decay;
            lbim_pkg::OFF_UPPER_THR_2: prdata_nxt[7:0] = cfg2_r.upper;
            lbim_pkg::OFF_LOWER_THR_2: prdata_nxt[7:0] = cfg2_r.lower;
            lbim_pkg::OFF_SIZE_2: prdata_nxt[7:0] = cfg2_r.size;
            lbim_pkg::OFF_DECAY_SEL_2: prdata_nxt[1:0] = cfg2_r.decay;
            lbim_pkg::OFF_CFG_SEL: prdata_nxt[NUM_INPUTS-1:0] = cfg_sel_r;
            lbim_pkg::OFF_ALARM: prdata_nxt[NUM_INPUTS-1:0] = alarm_r;
            lbim_pkg::OFF_IRQ_STAT: prdata_nxt[NUM_INPUTS-1:0] = stat_r;
            lbim_pkg::OFF_IRQ_MASK: prdata_nxt[NUM_INPUTS-1:0] = mask_r;
            default: prdata_nxt[7:0] = fill_sel;
        endcase
    end

    // APB answer: data captured in setup, pready high in the access cycle.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata_o <= '0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else if (clk_en_i) begin
            pready_o <= psel_i && !penable_i;
            pslverr_o <= 1'b0;
            if (rd_en) begin
                prdata_o <= prdata_nxt;
            end
        end
    end
endmodule
`default_nettype wire

// [hw/lbim_pkg.sv]
// Package of constants and types for the leaky bucket input monitor.
`default_nettype none
package lbim_pkg;
    // Register word indices; the APB byte address is four times the index.
    localparam logic [7:0] IDX_UPPER_THR_1 = 8'h54;
    localparam logic [7:0] IDX_LOWER_THR_1 = 8'h55;
    localparam logic [7:0] IDX_SIZE_1 = 8'h56;
    localparam logic [7:0] IDX_DECAY_SEL_1 = 8'h57;
    localparam logic [7:0] IDX_UPPER_THR_2 = 8'h58;
    localparam logic [7:0] IDX_LOWER_THR_2 = 8'h59;
    localparam logic [7:0] IDX_SIZE_2 = 8'h5a;
    localparam logic [7:0] IDX_DECAY_SEL_2 = 8'h5b;
    localparam logic [7:0] IDX_CFG_SEL = 8'h60;
    localparam logic [7:0] IDX_ALARM = 8'h61;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h62;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h63;
    localparam logic [7:0] IDX_FILL_0 = 8'h64;
    // Register byte addresses on the APB bus.
    localparam logic [9:0] OFF_UPPER_THR_1 = {IDX_UPPER_THR_1, 2'b00};
    localparam logic [9:0] OFF_LOWER_THR_1 = {IDX_LOWER_THR_1, 2'b00};
    localparam logic [9:0] OFF_SIZE_1 = {IDX_SIZE_1, 2'b00};
    localparam logic [9:0] OFF_DECAY_SEL_1 = {IDX_DECAY_SEL_1, 2'b00};
    localparam logic [9:0] OFF_UPPER_THR_2 = {IDX_UPPER_THR_2, 2'b00};
    localparam logic [9:0] OFF_LOWER_THR_2 = {IDX_LOWER_THR_2, 2'b00};
    localparam logic [9:0] OFF_SIZE_2 = {IDX_SIZE_2, 2'b00};
    localparam logic [9:0] OFF_DECAY_SEL_2 = {IDX_DECAY_SEL_2, 2'b00};
    localparam logic [9:0] OFF_CFG_SEL = {IDX_CFG_SEL, 2'b00};
    localparam logic [9:0] OFF_ALARM = {IDX_ALARM, 2'b00};
    localparam logic [9:0] OFF_IRQ_STAT = {IDX_IRQ_STAT, 2'b00};
    localparam logic [9:0] OFF_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
    localparam logic [9:0] OFF_FILL_0 = {IDX_FILL_0, 2'b00};
    // Reset values.
    localparam logic [7:0] RST_UPPER_THR = 8'h06;
    localparam logic [7:0] RST_LOWER_THR = 8'h04;
    localparam logic [7:0] RST_SIZE = 8'h08;
    localparam logic [1:0] RST_DECAY_SEL = 2'h1;
    // Monitoring cycle length.
    localparam int CYCLE_MS = 128;
    localparam int CLK_KHZ = 125000;
    localparam int CYCLE_CLKS = CYCLE_MS * CLK_KHZ;
    // One set of leaky bucket settings.
    typedef struct packed {
        logic [7:0] upper;
        logic [7:0] lower;
        logic [7:0] size;
        logic [1:0] decay;
    } lbim_cfg_t;
endpackage
`default_nettype wire

// [bench/lbim_properties.sv]
// Port-level checker for the leaky bucket input monitor.
`default_nettype none
module lbim_properties #(
    parameter int NUM_INPUTS = 4
) (
    // Clock, reset and enable.
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // APB slave side.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [9:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Alarms.
    input wire logic [NUM_INPUTS-1:0] alarm_o,
    input wire logic irq_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    // A setup cycle only counts while the block runs, since a low enable freezes it.
    wire logic setup = psel_i && !penable_i && clk_en_i;
    wire logic rd_setup = setup && !pwrite_i;
    ready_in_access_a: assert property (setup |=> pready_o) else $error("pready late");
    ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("pready stuck");
    no_slverr_a: assert property (!pslverr_o) else $error("pslverr raised");
    reset_clear_a: assert property ($rose(rst_b_i) |-> alarm_o == '0 && !irq_o && !pready_o)
        else $error("outputs not clear after reset");
    unmapped_zero_a: assert property (rd_setup && paddr_i == 10'h3fc |=> prdata_o == 32'h0)
        else $error("unmapped read not zero");
    decay_width_a: assert property (rd_setup && paddr_i == lbim_pkg::OFF_DECAY_SEL_1
        |=> prdata_o[31:2] == 30'h0)
        else $error("decay select upper bits set");
    thr_width_a: assert property (rd_setup && paddr_i == lbim_pkg::OFF_UPPER_THR_2
        |=> prdata_o[31:8] == 24'h0)
        else $error("threshold upper bits set");
    data_hold_a: assert property (!rd_setup |=> $stable(prdata_o)) else $error("prdata moved");
    freeze_a: assert property (!clk_en_i |=> $stable(alarm_o) && $stable(irq_o))
        else $error("state moved while frozen");
    alarm_seen_c: cover property ($rose(alarm_o[0]));
    irq_seen_c: cover property ($rose(irq_o));
    unmapped_c: cover property (rd_setup && paddr_i == 10'h3fc);
endmodule
bind lbim_monitor lbim_properties #(.NUM_INPUTS(NUM_INPUTS)) u_props (.sys_clk_i, .rst_b_i,
    .clk_en_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o,
    .alarm_o, .irq_o);
`default_nettype wire

// [bench/lbim_monitor_bench.sv]
// Self-checking bench for the leaky bucket input monitor.
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module lbim_monitor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CYC = 20;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic [3:0] fault_i = 4'h0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [9:0] paddr_i = 10'h0;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic irq_o;
    logic [3:0] alarm_o;
    logic [31:0] rd;
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;
    // Free-running clock and a cycle count used to time decrements.
    always #4 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) cyc <= cyc + 1;
    lbim_monitor #(.NUM_INPUTS(4), .CYCLE_CLKS(CYC)) u_dut (.sys_clk_i, .rst_b_i, .clk_en_i,
        .fault_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
        .pslverr_o, .alarm_o, .irq_o);
    task automatic close_out();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // One APB transfer; read data lands in rd at the edge that samples pready.
    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        rd = prdata_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        `CHK(n < 50, 1'b1)
    endtask
    // Polls a fill count; the poll spacing limits timing resolution to about three cycles.
    task automatic wait_fill(input int i, input logic [7:0] v, output int t);
        int k;
        for (k = 0; k < 400; k++) begin
            apb(1'b0, lbim_pkg::OFF_FILL_0 + 10'(i * 4), 32'h0);
            if (rd[7:0] === v) break;
        end
        t = cyc;
        `CHK(k < 400, 1'b1)
    endtask
    task automatic t_regs();
        apb(1'b0, lbim_pkg::OFF_UPPER_THR_2, 32'h0);
        `CHK(rd, 32'h06)
        apb(1'b0, lbim_pkg::OFF_DECAY_SEL_1, 32'h0);
        `CHK(rd, 32'h01)
        apb(1'b1, 10'h3fc, 32'hffff_ffff);
        apb(1'b0, 10'h3fc, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b1, lbim_pkg::OFF_DECAY_SEL_1, 32'hff);
        apb(1'b0, lbim_pkg::OFF_DECAY_SEL_1, 32'h0);
        `CHK(rd, 32'h03)
        clk_en_i <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
        clk_en_i <= 1'b1;
    endtask
    task automatic t_fill();
        int t;
        apb(1'b1, lbim_pkg::OFF_IRQ_MASK, 32'h3);
        apb(1'b1, lbim_pkg::OFF_LOWER_THR_2, 32'h1);
        apb(1'b1, lbim_pkg::OFF_UPPER_THR_2, 32'h3);
        apb(1'b1, lbim_pkg::OFF_SIZE_2, 32'h5);
        apb(1'b1, lbim_pkg::OFF_SIZE_1, 32'h6);
        apb(1'b1, lbim_pkg::OFF_CFG_SEL, 32'h2);
        fault_i <= 4'h3;
        wait_fill(1, 8'h3, t);
        repeat (3) @(posedge sys_clk_i);
        `CHK(alarm_o[1:0], 2'b10)
        wait_fill(0, 8'h6, t);
        repeat (CYC * 3) @(posedge sys_clk_i);
        `CHK(alarm_o, 4'h3)
        `CHK(irq_o, 1'b1)
        apb(1'b0, lbim_pkg::OFF_FILL_0, 32'h0);
        `CHK(rd, 32'h6)
        apb(1'b0, lbim_pkg::OFF_FILL_0 + 10'h4, 32'h0);
        `CHK(rd, 32'h5)
        apb(1'b0, lbim_pkg::OFF_FILL_0 + 10'h8, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, lbim_pkg::OFF_IRQ_STAT, 32'h0);
        `CHK(rd, 32'h3)
        apb(1'b1, lbim_pkg::OFF_IRQ_MASK, 32'h0);
        repeat (2) @(posedge sys_clk_i);
        `CHK(irq_o, 1'b0)
        apb(1'b1, lbim_pkg::OFF_IRQ_MASK, 32'h3);
        apb(1'b1, lbim_pkg::OFF_IRQ_STAT, 32'h3);
        repeat (2) @(posedge sys_clk_i);
        `CHK(irq_o, 1'b0)
    endtask
    // Each decay code must space decrements by one, two, four or eight cycles.
    task automatic t_decay();
        int t1;
        int t2;
        int exp;
        for (int d = 0; d < 4; d++) begin
            exp = CYC << d;
            apb(1'b1, lbim_pkg::OFF_DECAY_SEL_1, 32'(d));
            fault_i <= 4'h0;
            wait_fill(0, 8'h5, t1);
            `CHK(alarm_o[0], 1'b1)
            wait_fill(0, 8'h4, t2);
            repeat (3) @(posedge sys_clk_i);
            `CHK(alarm_o[0], 1'b0)
            `CHK(t2 - t1 > exp - 5 && t2 - t1 < exp + 5, 1'b1)
            fault_i <= 4'h1;
            wait_fill(0, 8'h6, t1);
        end
    endtask
    // Main sequence after the reset hold.
    initial begin
        repeat (16) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        t_regs();
        t_fill();
        t_decay();
        close_out();
    end
    // Watchdog well beyond the thousand or so cycles the sequence needs.
    initial begin
        #200000;
        errors++;
        close_out();
    end
endmodule
`default_nettype wire
